// File: verilog/spi_ss_pkg.sv
// shared constants and types for the select-controlled serial port and its master
`default_nettype none
package spi_ss_pkg;
   // clock and link timing
   localparam int CLK_PERIOD_NS = 40;                  // core clock period
   localparam int SCK_HALF_NS   = 480;                 // master serial clock half period
   localparam int SCK_HALF_CYC  = (SCK_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BITS_PER_BYTE = 8;                   // bits per transfer
   localparam int SYNC_STAGES   = 3;                   // pin synchroniser depth

   // device register byte offsets
   localparam logic [4:0] DEV_CTRL_OFS  = 5'h00;       // serial_port_control
   localparam logic [4:0] DEV_BUF_OFS   = 5'h04;       // serial_buffer_reg
   localparam logic [4:0] DEV_STAT_OFS  = 5'h08;       // clock edge select and buffer full
   localparam logic [4:0] DEV_ISTAT_OFS = 5'h0c;       // sticky event bits
   localparam logic [4:0] DEV_IMASK_OFS = 5'h10;       // event mask

   // master register byte offsets
   localparam logic [4:0] MST_CTRL_OFS  = 5'h00;       // polarity, phase, select
   localparam logic [4:0] MST_DATA_OFS  = 5'h04;       // write starts a byte, read gives last byte
   localparam logic [4:0] MST_STAT_OFS  = 5'h08;       // busy and done

   // serial_port_control, status, event and master register fields
   localparam int CTRL_WRITE_COLLISION_FLAG_BIT = 7;                   // write_collision_flag
   localparam int CTRL_OVF_BIT  = 6;                   // receive_overflow_flag
   localparam int CTRL_EN_BIT   = 5;                   // port_enable_bit
   localparam int CTRL_CKP_BIT  = 4;                   // clock_idle_polarity
   localparam int STAT_CKE_BIT  = 6;                   // clock edge select
   localparam int STAT_BF_BIT   = 0;                   // buffer_full_flag
   localparam int EV_BYTE_BIT   = 0;                   // port_interrupt_flag
   localparam int EV_WRITE_COLLISION_FLAG_BIT   = 1;
   localparam int EV_OVF_BIT    = 2;
   localparam int EV_W          = 3;
   localparam int MCTRL_CPOL_BIT = 0;
   localparam int MCTRL_CPHA_BIT = 1;
   localparam int MCTRL_SEL_BIT  = 2;
   localparam int MSTAT_BUSY_BIT = 0;
   localparam int MSTAT_DONE_BIT = 1;

   // values after reset
   localparam logic [7:0]      CTRL_RST  = 8'h00;
   localparam logic [EV_W-1:0] EV_RST    = 3'h0;
   localparam logic [2:0]      MCTRL_RST = 3'h0;

   // port_mode_field codes
   localparam logic [3:0] MODE_MST_DIV4  = 4'h0;
   localparam logic [3:0] MODE_MST_DIV16 = 4'h1;
   localparam logic [3:0] MODE_MST_DIV64 = 4'h2;
   localparam logic [3:0] MODE_MST_TMR   = 4'h3;
   localparam logic [3:0] MODE_SLV_SEL   = 4'h4;
   localparam logic [3:0] MODE_SLV_FREE  = 4'h5;

   typedef enum {PM_MASTER, PM_SLAVE_SEL, PM_SLAVE_FREE, PM_NONE} port_mode_t;
   typedef enum {M_IDLE, M_RUN, M_TAIL} mst_state_t;
endpackage
`default_nettype wire

// File: verilog/spi_link_if.sv
// serial link between the master end and the select-controlled slave
`default_nettype none
interface spi_link_if;
   logic sck;        // serial clock from master
   logic sel_n;      // active-low select from master
   logic mosi;       // serial_in_pin of the slave
   logic miso;       // serial_out_pin value from slave
   logic miso_oe;    // slave drives serial_out_pin
   logic miso_line;  // resolved line, pulled high when released
   assign miso_line = miso_oe ? miso : 1'b1;
   modport master (output sck, output sel_n, output mosi, input miso_line);
   modport slave  (input sck, input sel_n, input mosi, output miso, output miso_oe);
endinterface
`default_nettype wire

// File: verilog/spi_ss_slave.sv
// select-controlled byte-wide serial slave with avalon register access
`default_nettype none
// What this block does
// - select obeyed only in mode 0100
// - software makes the select pin an input
// - select low: shift as ordinary slave
// - select high: reset logic, release data out
// - leading-edge slave mode needs select control
// - serial reset clears bit counter
// - software reloads shift register after reset
// - shifting follows external clock, not core; here the pins are synchronised and shifted on the core clk
// - eight bits set flag, may wake
// - software sets serial pin directions
// - buffer write while busy: ignore, collision
// - byte while full: overflow, discard, stop
// - enable bit assigns pins to port in modes 0000 to 0101
module spi_ss_slave
   import spi_ss_pkg::*;
(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // avalon-mm register slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // system side
   output logic             irq,
   output logic             pins_assigned,
   // serial link
   spi_link_if.slave        link
);
   ////////////////////////////////////////////////////////////////////////////
   // state
   logic [SYNC_STAGES-1:0][2:0] sync_r, sync_nxt;  // pin synchroniser, order sck, sel_n, mosi
   logic [2:0]        lvl_r, lvl_nxt;              // agreed pin levels
   logic [7:0]        ctrl_r, ctrl_nxt;            // serial_port_control
   logic              cke_r, cke_nxt;              // data changes on leading edge when set
   logic              bf_r, bf_nxt;                // buffer_full_flag
   logic [7:0]        buf_r, buf_nxt;              // serial_buffer_reg, receive side
   logic [7:0]        sr_r, sr_nxt;                // serial_shift_reg, transmit side
   logic [7:0]        rx_r, rx_nxt;                // receive assembly
   logic [2:0]        cnt_r, cnt_nxt;              // bit counter
   logic              txs_r, txs_nxt;              // first bit already presented
   logic [EV_W-1:0]   ev_r, ev_nxt;                // sticky events
   logic [EV_W-1:0]   mask_r, mask_nxt;            // event mask
   logic [31:0]       rdata_r, rdata_nxt;
   logic              wait_r, wait_nxt;
   logic              irq_r, irq_nxt;
   logic              pins_r, pins_nxt;
   logic              miso_r, miso_nxt;
   logic              oe_r, oe_nxt;

   // combinational helpers
   port_mode_t        pmode;                       // decoded port_mode_field
   logic              slave_on;                    // enabled and in a slave variant
   logic              ser_rst;                     // serial logic held in reset
   logic              halted;                      // overflow stops communication
   logic              edge_seen, leading, smp_edge, sft_edge;
   logic              acc, wr, rd, done;
   logic [7:0]        byte_in;

   ////////////////////////////////////////////////////////////////////////////
   // mode decode and serial edge detection
   always_comb begin
      case (ctrl_r[3:0])
         MODE_MST_DIV4, MODE_MST_DIV16,
         MODE_MST_DIV64, MODE_MST_TMR: pmode = PM_MASTER;
         MODE_SLV_SEL:                 pmode = PM_SLAVE_SEL;
         MODE_SLV_FREE:                pmode = PM_SLAVE_FREE;
         default:                      pmode = PM_NONE;
      endcase
      // master clocking is not built here, so only slave variants run the shifter
      slave_on = ctrl_r[CTRL_EN_BIT] && (pmode == PM_SLAVE_SEL || pmode == PM_SLAVE_FREE);
      // select only counts in the select-controlled variant
      ser_rst  = !slave_on || (pmode == PM_SLAVE_SEL && lvl_r[1]);
      halted   = ctrl_r[CTRL_OVF_BIT];
      // a pin level changes once the second and third stages agree
      lvl_nxt  = lvl_r;
      for (int i = 0; i < 3; i++) begin
         if (sync_r[1][i] == sync_r[2][i]) begin
            lvl_nxt[i] = sync_r[2][i];
         end
      end
      sync_nxt = {sync_r[1:0], {link.mosi, link.sel_n, link.sck}};
      edge_seen = lvl_nxt[0] != lvl_r[0];
      // leading edge is the one leaving the idle level
      leading  = lvl_nxt[0] != ctrl_r[CTRL_CKP_BIT];
      // edge select set: sample on trailing edge, change on leading one
      smp_edge = edge_seen && (leading != cke_r);
      sft_edge = edge_seen && (leading == cke_r);
      acc      = (read || write) && !wait_r;
      wr       = write && acc;
      rd       = read && acc;
      byte_in  = {rx_r[6:0], lvl_r[2]};
      done     = !ser_rst && !halted && smp_edge && cnt_r == 3'(BITS_PER_BYTE - 1);
   end

   ////////////////////////////////////////////////////////////////////////////
   // serial shifter, buffer, flags and registers
   always_comb begin
      ctrl_nxt = ctrl_r;
      cke_nxt  = cke_r;
      bf_nxt   = bf_r;
      buf_nxt  = buf_r;
      sr_nxt   = sr_r;
      rx_nxt   = rx_r;
      cnt_nxt  = cnt_r;
      txs_nxt  = txs_r;
      ev_nxt   = ev_r;
      mask_nxt = mask_r;
      // software side effects first, hardware sets below win over clears
      if (wr) begin
         case (address)
            DEV_CTRL_OFS:  ctrl_nxt = writedata[7:0];
            DEV_STAT_OFS:  cke_nxt  = writedata[STAT_CKE_BIT];
            DEV_ISTAT_OFS: ev_nxt   = ev_r & ~writedata[EV_W-1:0];
            DEV_IMASK_OFS: mask_nxt = writedata[EV_W-1:0];
            default: ;
         endcase
      end
      if (rd && address == DEV_BUF_OFS) begin
         bf_nxt = 1'b0;                                   // reading the buffer empties it
      end
      if (ser_rst) begin
         // counter cleared; shift contents kept, software must reload
         cnt_nxt = 3'h0;
         txs_nxt = 1'b0;
      end else if (!halted) begin
         if (smp_edge) begin
            rx_nxt  = byte_in;
            cnt_nxt = cnt_r + 3'h1;
         end
         if (sft_edge) begin
            if (cke_r && !txs_r) begin
               txs_nxt = 1'b1;                            // bit 7 already on the pin
            end else begin
               sr_nxt = {sr_r[6:0], 1'b0};
            end
         end
      end
      if (done) begin
         txs_nxt = 1'b0;
         ev_nxt[EV_BYTE_BIT] = 1'b1;
         if (bf_r) begin
            // new byte is dropped and the port goes quiet
            ctrl_nxt[CTRL_OVF_BIT] = 1'b1;
            ev_nxt[EV_OVF_BIT]     = 1'b1;
         end else begin
            buf_nxt = byte_in;
            bf_nxt  = 1'b1;
         end
      end
      if (wr && address == DEV_BUF_OFS) begin
         if (cnt_r != 3'h0 || txs_r) begin
            // mid-byte load would corrupt the bit in flight
            ctrl_nxt[CTRL_WRITE_COLLISION_FLAG_BIT] = 1'b1;
            ev_nxt[EV_WRITE_COLLISION_FLAG_BIT]     = 1'b1;
         end else begin
            sr_nxt = writedata[7:0];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bus answer and pin drive
   always_comb begin
      // one wait cycle per access: readdata is ready when waitrequest drops
      wait_nxt  = !((read || write) && wait_r);
      rdata_nxt = 32'h0;
      case (address)
         DEV_CTRL_OFS:  rdata_nxt[7:0] = ctrl_r;
         DEV_BUF_OFS:   rdata_nxt[7:0] = buf_r;
         DEV_STAT_OFS:  begin
            rdata_nxt[STAT_CKE_BIT] = cke_r;
            rdata_nxt[STAT_BF_BIT]  = bf_r;
         end
         DEV_ISTAT_OFS: rdata_nxt[EV_W-1:0] = ev_r;
         DEV_IMASK_OFS: rdata_nxt[EV_W-1:0] = mask_r;
         default:       rdata_nxt = 32'h0;          // unmapped reads as zero
      endcase
      // level interrupt doubles as the wake request
      irq_nxt  = |(ev_nxt & mask_nxt);
      pins_nxt = ctrl_nxt[CTRL_EN_BIT] && ctrl_nxt[3:0] <= MODE_SLV_FREE;
      miso_nxt = sr_nxt[7];
      oe_nxt   = !ser_rst && !halted;
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         // start at the idle levels (clock low, select high) so no false edge follows reset
         sync_r <= {SYNC_STAGES{3'h2}};
         lvl_r  <= 3'h2;
         ctrl_r <= CTRL_RST;
         cke_r  <= 1'b0;
         bf_r   <= 1'b0;
         buf_r  <= 8'h00;
         sr_r   <= 8'h00;
         rx_r   <= 8'h00;
         cnt_r  <= 3'h0;
         txs_r  <= 1'b0;
         ev_r   <= EV_RST;
         mask_r <= EV_RST;
         rdata_r <= 32'h0;
         wait_r <= 1'b1;
         irq_r  <= 1'b0;
         pins_r <= 1'b0;
         miso_r <= 1'b0;
         oe_r   <= 1'b0;
      end else begin
         sync_r <= sync_nxt;
         lvl_r  <= lvl_nxt;
         ctrl_r <= ctrl_nxt;
         cke_r  <= cke_nxt;
         bf_r   <= bf_nxt;
         buf_r  <= buf_nxt;
         sr_r   <= sr_nxt;
         rx_r   <= rx_nxt;
         cnt_r  <= cnt_nxt;
         txs_r  <= txs_nxt;
         ev_r   <= ev_nxt;
         mask_r <= mask_nxt;
         rdata_r <= rdata_nxt;
         wait_r <= wait_nxt;
         irq_r  <= irq_nxt;
         pins_r <= pins_nxt;
         miso_r <= miso_nxt;
         oe_r   <= oe_nxt;
      end
   end

   assign readdata      = rdata_r;
   assign waitrequest   = wait_r;
   assign irq           = irq_r;
   assign pins_assigned = pins_r;
   assign link.miso     = miso_r;
   assign link.miso_oe  = oe_r;
endmodule // spi_ss_slave
`default_nettype wire

// File: verilog/spi_ss_master.sv
// serial master end that drives clock, select and data toward the slave
`default_nettype none
module spi_ss_master
   import spi_ss_pkg::*;
#(
   parameter int HALF_CYC = SCK_HALF_CYC               // core cycles per clock half
)(
   // clock and reset
   input  wire logic        clk,
   input  wire logic        sys_rst,
   // avalon-mm register slave
   input  wire logic [4:0]  address,
   input  wire logic        read,
   input  wire logic        write,
   input  wire logic [31:0] writedata,
   output logic      [31:0] readdata,
   output logic             waitrequest,
   // serial link
   spi_link_if.master       link
);
   // the slave needs several core cycles to see each edge
   if (HALF_CYC < 8) begin : g_half_chk
      $error("HALF_CYC below 8 leaves the slave no time to answer");
   end

   ////////////////////////////////////////////////////////////////////////////
   // state
   mst_state_t        st_r, st_nxt;
   logic [2:0]        mctrl_r, mctrl_nxt;          // cpol, cpha, select
   logic [15:0]       half_r, half_nxt;            // half period counter
   logic [4:0]        edge_r, edge_nxt;            // clock edges issued
   logic [7:0]        tx_r, tx_nxt, rx_r, rx_nxt;
   logic              done_r, done_nxt;
   logic              sck_r, sck_nxt, mosi_r, mosi_nxt, sel_r, sel_nxt;
   logic [SYNC_STAGES-1:0] ms_r;                   // miso synchroniser
   logic              mlvl_r, mlvl_nxt;
   logic [31:0]       rdata_r, rdata_nxt;
   logic              wait_r, wait_nxt;
   logic              wr, rd, cpha;

   ////////////////////////////////////////////////////////////////////////////
   // sequencer and registers, next values
   always_comb begin
      st_nxt    = st_r;
      mctrl_nxt = mctrl_r;
      half_nxt  = half_r;
      edge_nxt  = edge_r;
      tx_nxt    = tx_r;
      rx_nxt    = rx_r;
      done_nxt  = done_r;
      sck_nxt   = sck_r;
      mosi_nxt  = mosi_r;
      mlvl_nxt  = (ms_r[1] == ms_r[2]) ? ms_r[2] : mlvl_r;
      wr        = write && !wait_r;
      rd        = read && !wait_r;
      cpha      = mctrl_r[MCTRL_CPHA_BIT];
      if (wr && address == MST_CTRL_OFS) begin
         mctrl_nxt = writedata[2:0];
      end
      if (rd && address == MST_DATA_OFS) begin
         done_nxt = 1'b0;
      end
      case (st_r)
         M_IDLE: begin
            sck_nxt = mctrl_r[MCTRL_CPOL_BIT];
            if (wr && address == MST_DATA_OFS) begin
               tx_nxt   = writedata[7:0];
               half_nxt = 16'h0;
               edge_nxt = 5'h0;
               st_nxt   = M_RUN;
               if (!cpha) begin
                  // first bit must stand before the first edge
                  mosi_nxt = writedata[7];
                  tx_nxt   = {writedata[6:0], 1'b0};
               end
            end
         end
         M_RUN: begin
            if (half_r == 16'(HALF_CYC - 1)) begin
               half_nxt = 16'h0;
               sck_nxt  = !sck_r;
               edge_nxt = edge_r + 5'h1;
               if ((edge_r[0] == 1'b0) != cpha) begin
                  rx_nxt = {rx_r[6:0], mlvl_r};
               end else begin
                  mosi_nxt = tx_r[7];
                  tx_nxt   = {tx_r[6:0], 1'b0};
               end
               if (edge_r == 5'(2 * BITS_PER_BYTE - 1)) begin
                  st_nxt = M_TAIL;
               end
            end else begin
               half_nxt = half_r + 16'h1;
            end
         end
         M_TAIL: begin
            // hold the last level one half period before going idle
            if (half_r == 16'(HALF_CYC - 1)) begin
               st_nxt   = M_IDLE;
               done_nxt = 1'b1;
            end else begin
               half_nxt = half_r + 16'h1;
            end
         end
         default: st_nxt = M_IDLE;
      endcase
      // select is software's: it must be low for leading-edge transfers
      sel_nxt   = !mctrl_nxt[MCTRL_SEL_BIT];
      wait_nxt  = !((read || write) && wait_r);
      rdata_nxt = 32'h0;
      case (address)
         MST_CTRL_OFS: rdata_nxt[2:0] = mctrl_r;
         MST_DATA_OFS: rdata_nxt[7:0] = rx_r;
         MST_STAT_OFS: begin
            rdata_nxt[MSTAT_BUSY_BIT] = st_r != M_IDLE;
            rdata_nxt[MSTAT_DONE_BIT] = done_r;
         end
         default:      rdata_nxt = 32'h0;
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // registers
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         st_r    <= M_IDLE;
         mctrl_r <= MCTRL_RST;
         half_r  <= 16'h0;
         edge_r  <= 5'h0;
         tx_r    <= 8'h00;
         rx_r    <= 8'h00;
         done_r  <= 1'b0;
         sck_r   <= 1'b0;
         mosi_r  <= 1'b0;
         sel_r   <= 1'b1;
         ms_r    <= '1;
         mlvl_r  <= 1'b1;
         rdata_r <= 32'h0;
         wait_r  <= 1'b1;
      end else begin
         st_r    <= st_nxt;
         mctrl_r <= mctrl_nxt;
         half_r  <= half_nxt;
         edge_r  <= edge_nxt;
         tx_r    <= tx_nxt;
         rx_r    <= rx_nxt;
         done_r  <= done_nxt;
         sck_r   <= sck_nxt;
         mosi_r  <= mosi_nxt;
         sel_r   <= sel_nxt;
         ms_r    <= {ms_r[1:0], link.miso_line};
         mlvl_r  <= mlvl_nxt;
         rdata_r <= rdata_nxt;
         wait_r  <= wait_nxt;
      end
   end

   assign readdata    = rdata_r;
   assign waitrequest = wait_r;
   assign link.sck    = sck_r;
   assign link.mosi   = mosi_r;
   assign link.sel_n  = sel_r;
endmodule // spi_ss_master
`default_nettype wire

// File: testbench/spi_link_props.sv
// assertions watching the serial link between the master end and the slave
`default_nettype none
module spi_link_props (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // link signals
   input wire logic sck,
   input wire logic sel_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic miso_line
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////////////////////////
   // select passes three sync flops, so six cycles covers the lag
   property p_oe_off; sel_n [*6] |-> !miso_oe; endproperty
   a_oe_off: assert property (p_oe_off) else $error("data out driven while deselected");
   property p_oe_drop; $rose(sel_n) |-> ##[1:6] !miso_oe; endproperty
   a_oe_drop: assert property (p_oe_drop) else $error("data out not released after deselect");
   property p_oe_lag; $fell(sel_n) |-> (!miso_oe) [*3]; endproperty
   a_oe_lag: assert property (p_oe_lag) else $error("data out driven before select seen");
   property p_oe_rise; $rose(miso_oe) |-> !sel_n; endproperty
   a_oe_rise: assert property (p_oe_rise) else $error("data out enabled without select");
   // released line must show the pull-up, never a stale bit
   property p_line_pull; !miso_oe |-> miso_line; endproperty
   a_line_pull: assert property (p_line_pull) else $error("released data line not high");
   property p_line_follow; miso_oe |-> (miso_line == miso); endproperty
   a_line_follow: assert property (p_line_follow) else $error("data line differs from driven bit");
   // the slave needs more than eight core cycles per clock half
   property p_sck_half; $changed(sck) |=> $stable(sck) [*8]; endproperty
   a_sck_half: assert property (p_sck_half) else $error("serial clock half period too short");
   property p_sel_clean; $fell(sel_n) |-> $stable(sck); endproperty
   a_sel_clean: assert property (p_sel_clean) else $error("select fell on a clock edge");
   ////////////////////////////////////////////////////////////
   c_sel: cover property ($fell(sel_n));
   c_oe: cover property ($rose(miso_oe));
   c_bit: cover property (!sel_n && $rose(sck) && mosi);
endmodule // spi_link_props
`default_nettype wire

// File: testbench/tb.sv
// self-checking bench: master end and select-controlled slave joined by the link
`default_nettype none
module tb
   import spi_ss_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk = 1'b0;        // core clock
   logic        sys_rst = 1'b1;    // sync reset
   logic [4:0]  address [2];       // index 0 slave bus, 1 master bus
   logic        read [2];
   logic        write [2];
   logic [31:0] writedata [2];
   logic [31:0] readdata [2];
   logic        waitrequest [2];
   logic        irq;               // slave event request
   logic        pins_assigned;     // pins given to port
   logic [7:0]  cap_mosi;          // bits seen on the wire
   logic [7:0]  cap_miso;
   logic [31:0] q;                 // last read word
   int          err_count = 0;
   int          checks_done = 0;
   spi_link_if link ();
   ////////////////////////////////////////////////////////////
   spi_ss_slave u_spi_ss_slave (.clk(clk), .sys_rst(sys_rst), .address(address[0]), .read(read[0]),
      .write(write[0]), .writedata(writedata[0]), .readdata(readdata[0]), .waitrequest(waitrequest[0]),
      .irq(irq), .pins_assigned(pins_assigned), .link(link.slave));
   spi_ss_master u_spi_ss_master (.clk(clk), .sys_rst(sys_rst), .address(address[1]), .read(read[1]),
      .write(write[1]), .writedata(writedata[1]), .readdata(readdata[1]), .waitrequest(waitrequest[1]),
      .link(link.master));
   spi_link_props u_spi_link_props (.clk(clk), .sys_rst(sys_rst), .sck(link.sck), .sel_n(link.sel_n),
      .mosi(link.mosi), .miso(link.miso), .miso_oe(link.miso_oe), .miso_line(link.miso_line));
   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   // capture on leading edges while selected (idle-low clock only)
   always @(posedge link.sck) begin
      if (!link.sel_n) begin
         cap_mosi <= {cap_mosi[6:0], link.mosi};
         cap_miso <= {cap_miso[6:0], link.miso_line};
      end
   end
   ////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   // one avalon cycle: hold until waitrequest is sampled low
   task automatic bus(input int s, input logic wr, input logic [4:0] a, input logic [31:0] d);
      @(posedge clk);
      address[s] <= a;
      write[s] <= wr;
      read[s] <= !wr;
      writedata[s] <= d;
      // no cycle count assumed: only the watchdog ends a stuck wait
      do begin
         @(posedge clk);
      end while (waitrequest[s] !== 1'b0);
      q = readdata[s];
      read[s] <= 1'b0;
      write[s] <= 1'b0;
   endtask
   // poll master until done, then fetch its received byte into q
   task automatic wait_done();
      do begin
         bus(1, 1'b0, MST_STAT_OFS, 32'h0);
      end while (q[MSTAT_DONE_BIT] !== 1'b1);
      bus(1, 1'b0, MST_DATA_OFS, 32'h0);
   endtask
   task automatic xfer(input logic [7:0] tx);
      bus(1, 1'b1, MST_DATA_OFS, {24'h0, tx});
      wait_done();
   endtask
   task automatic t_reset();
      bus(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      chk("ctrl reset", q, {24'h0, CTRL_RST});
      bus(0, 1'b0, 5'h14, 32'h0);
      chk("unmapped", q, 32'h0);
      chk("pins reset", pins_assigned, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_byte();
      bus(0, 1'b1, DEV_CTRL_OFS, 32'h24);  // enable, select-controlled slave
      bus(1, 1'b1, MST_CTRL_OFS, 32'h4);
      repeat (8) @(posedge clk);
      chk("pins", pins_assigned, 32'h1);
      bus(0, 1'b1, DEV_BUF_OFS, 32'ha5);
      xfer(8'h3c);
      chk("master rx", q, 32'ha5);
      chk("wire mosi", cap_mosi, 32'h3c);
      chk("wire miso", cap_miso, 32'ha5);
      chk("masked irq", irq, 32'h0);
      bus(0, 1'b1, DEV_IMASK_OFS, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq", irq, 32'h1);
      bus(0, 1'b0, DEV_BUF_OFS, 32'h0);
      chk("slave rx", q, 32'h3c);
      bus(0, 1'b1, DEV_ISTAT_OFS, 32'h1);
      repeat (3) @(posedge clk);
      chk("irq cleared", irq, 32'h0);
      $display("test byte done");
   endtask
   task automatic t_coll_ovf();
      bus(0, 1'b1, DEV_BUF_OFS, 32'h11);
      bus(1, 1'b1, MST_DATA_OFS, 32'h77);
      repeat (60) @(posedge clk);          // bits in flight
      bus(0, 1'b1, DEV_BUF_OFS, 32'hff);
      bus(0, 1'b0, DEV_CTRL_OFS, 32'h0);
      chk("collision", q[CTRL_WRITE_COLLISION_FLAG_BIT], 32'h1);
      wait_done();
      chk("rx after collision", q, 32'h11);
      xfer(8'h99);                          // buffer still full
      bus(0, 1'b0, DEV_ISTAT_OFS, 32'h0);
      chk("overflow event", q[EV_OVF_BIT], 32'h1);
      chk("stopped", link.miso_oe, 32'h0);
      bus(0, 1'b0, DEV_BUF_OFS, 32'h0);
      chk("kept byte", q, 32'h77);
      bus(0, 1'b1, DEV_CTRL_OFS, 32'h24);
      bus(0, 1'b1, DEV_ISTAT_OFS, 32'h7);
      $display("test collision overflow done");
   endtask
   task automatic t_desel();
      bus(0, 1'b1, DEV_BUF_OFS, 32'h3c);
      bus(1, 1'b1, MST_DATA_OFS, 32'h0f);
      repeat (70) @(posedge clk);
      bus(1, 1'b1, MST_CTRL_OFS, 32'h0);   // drop select mid-byte
      wait_done();
      chk("released", link.miso_oe, 32'h0);
      bus(0, 1'b0, DEV_ISTAT_OFS, 32'h0);
      chk("no byte", q[EV_BYTE_BIT], 32'h0);
      bus(1, 1'b1, MST_CTRL_OFS, 32'h4);
      repeat (8) @(posedge clk);
      bus(0, 1'b1, DEV_BUF_OFS, 32'h81);   // reload after serial reset
      xfer(8'h5a);
      chk("reload", q, 32'h81);
      bus(0, 1'b0, DEV_BUF_OFS, 32'h0);
      chk("realigned", q, 32'h5a);
      $display("test deselect done");
   endtask
   task automatic t_cpol_modes();
      // polarity changes only while deselected, else the idle move counts as a bit
      bus(1, 1'b1, MST_CTRL_OFS, 32'h1);
      bus(0, 1'b1, DEV_CTRL_OFS, 32'h34);
      repeat (8) @(posedge clk);
      chk("idle high", link.sck, 32'h1);
      bus(1, 1'b1, MST_CTRL_OFS, 32'h5);
      repeat (8) @(posedge clk);
      bus(0, 1'b1, DEV_BUF_OFS, 32'hc3);
      xfer(8'h3a);
      chk("rx idle high", q, 32'hc3);
      bus(0, 1'b0, DEV_BUF_OFS, 32'h0);
      chk("slave rx idle high", q, 32'h3a);
      // data changes on the leading edge: slave edge select and master phase set
      bus(0, 1'b1, DEV_STAT_OFS, 32'h40);
      bus(1, 1'b1, MST_CTRL_OFS, 32'h7);
      bus(0, 1'b1, DEV_BUF_OFS, 32'h96);
      xfer(8'h69);
      chk("rx leading edge", q, 32'h96);
      bus(0, 1'b0, DEV_BUF_OFS, 32'h0);
      chk("slave rx leading edge", q, 32'h69);
      for (int m = 0; m < 8; m++) begin
         bus(0, 1'b1, DEV_CTRL_OFS, 32'h20 | m);
         repeat (2) @(posedge clk);
         chk("mode pins", pins_assigned, {31'h0, m < 6});
      end
      bus(0, 1'b1, DEV_CTRL_OFS, 32'h04);
      repeat (2) @(posedge clk);
      chk("disabled pins", pins_assigned, 32'h0);
      $display("test polarity modes done");
   endtask
   ////////////////////////////////////////////////////////////
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask
   initial begin
      foreach (address[i]) begin
         address[i] = 5'h00;
         read[i] = 1'b0;
         write[i] = 1'b0;
         writedata[i] = 32'h0;
      end
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      t_reset();
      t_byte();
      t_coll_ovf();
      t_desel();
      t_cpol_modes();
      close_out();
   end
   // watchdog well beyond the few thousand cycles the tests need
   initial begin
      repeat (25000) @(posedge clk);
      err_count++;
      close_out();
   end
endmodule // tb
`default_nettype wire
